//--- verilog/mcm_regs.sv
// monitor configuration and interrupt mask registers with the conversion
// sequencer they steer. assumes a serial front end on link_clk_i issuing
// register requests, an adc on clock_i answering conv_req_o with conv_done_i.
// clock_i and link_clk_i are unrelated; each handshake crossing is a toggle and two flops, reset is two flops.
`timescale 1ns/100ps
`default_nettype none

module mcm_regs
    import mcm_pkg::*;
#(
    parameter int TMO_CYCLES = `MCM_TMO_CYCLES
)
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic link_clk_i,
    input wire logic link_req_i,
    input wire logic link_we_i,
    input wire logic [7:0] link_addr_i,
    input wire logic [7:0] link_wdata_i,
    output logic link_busy_o,
    output logic [7:0] link_rdata_o,
    output logic link_done_o,
    input wire logic scl_i,
    output logic bus_abort_o,
    input wire logic monitor_start_i,
    input wire logic [1:0] pin_pair_sel_i,
    input wire logic conv_done_i,
    output logic conv_req_o,
    output mcm_cfg_type conv_cfg_o,
    output logic result_store_o,
    input wire logic [12:0] irq_src_i,
    output logic irq_active_o
);

    // widths of the averaging and timeout counters
    localparam int AVG_W = $clog2(`MCM_AVG_SAMPLES);
    localparam int TMO_W = $clog2(TMO_CYCLES + 1);

    // ------------------------------------------------------------------
    // link domain: request capture and answer
    // ------------------------------------------------------------------
    logic lrst_meta_q, lrst_q;
    logic req_tog_q;
    mcm_req_type req_q;
    logic ack_meta_q, ack_sync_q, ack_seen_q;
    logic ack_tog_q;
    logic [7:0] core_rdata_q;

    // reset reaches the link domain through two flops
    always_ff @(posedge link_clk_i)
    begin
        lrst_meta_q <= reset_i;
        lrst_q <= lrst_meta_q;
    end

    // ack toggle back into the link domain; only ack_sync_q is read
    always_ff @(posedge link_clk_i)
    begin
        ack_meta_q <= ack_tog_q;
        ack_sync_q <= ack_meta_q;
    end

    // a request is held stable until the core toggles its ack back,
    // so the core may sample req_q without a word-wide synchroniser
    // requests that arrive while busy are dropped; the host waits for done
    // link_done_o pulses one cycle; link_rdata_o stands until the next pulse
    always_ff @(posedge link_clk_i)
    begin
        if (lrst_q)
        begin
            req_tog_q <= 1'b0;
            req_q <= '0;
            link_busy_o <= 1'b0;
            link_rdata_o <= 8'h00;
            link_done_o <= 1'b0;
            ack_seen_q <= 1'b0;
        end
        else
        begin
            ack_seen_q <= ack_sync_q;
            link_done_o <= 1'b0;
            if (link_busy_o && (ack_sync_q != ack_seen_q))
            begin
                link_rdata_o <= core_rdata_q;
                link_busy_o <= 1'b0;
                link_done_o <= 1'b1;
            end
            else if (!link_busy_o && link_req_i)
            begin
                req_q <= '{we: link_we_i, addr: link_addr_i, wdata: link_wdata_i};
                req_tog_q <= ~req_tog_q;
                link_busy_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // core domain: register file
    // ------------------------------------------------------------------
    logic req_meta_q, req_sync_q, req_seen_q;
    logic [7:0] ctrl_two_q, ctrl_three_q, mask_low_q;
    logic [4:0] mask_high_q;
    logic soft_rst_q;
    logic req_new;
    logic wr_two;

    // request toggle into the core domain; only req_sync_q is read
    always_ff @(posedge clock_i)
    begin
        req_meta_q <= req_tog_q;
        req_sync_q <= req_meta_q;
    end

    // a new request is any difference between the synced toggle and the last served;
    // the request word has been stable for two edges by then
    assign req_new = req_sync_q != req_seen_q;
    assign wr_two = req_new && req_q.we && (req_q.addr == `MCM_OFF_CONV_CTRL_TWO);

    // read mux; unmapped offsets read zero
    // writes answer zero, so every access returns a defined byte
    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        unique case (a)
            `MCM_OFF_CONV_CTRL_TWO: rd_mux = ctrl_two_q;
            `MCM_OFF_CONV_CTRL_THREE: rd_mux = ctrl_three_q;
            `MCM_OFF_IRQ_MASK_LOW: rd_mux = mask_low_q;
            `MCM_OFF_IRQ_MASK_HIGH: rd_mux = {3'h0, mask_high_q};
            default: rd_mux = 8'h00;
        endcase
    endfunction

    // handshake state is kept out of the soft reset so an in-flight
    // request still gets its answer
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            req_seen_q <= 1'b0;
            ack_tog_q <= 1'b0;
            core_rdata_q <= 8'h00;
        end
        else if (req_new)
        begin
            req_seen_q <= req_sync_q;
            ack_tog_q <= ~ack_tog_q;
            core_rdata_q <= req_q.we ? 8'h00 : rd_mux(req_q.addr);
        end
    end

    // software reset pulse, one cycle after the write
    // the delay lets the write itself finish before the registers clear
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            soft_rst_q <= 1'b0;
        else
            soft_rst_q <= wr_two && req_q.wdata[`MCM_BIT_SOFT_RST];
    end

    // config and mask registers; the reset bit is never stored so it reads 0
    // reserved high mask bits are not stored and read back as zero
    always_ff @(posedge clock_i)
    begin
        if (reset_i || soft_rst_q)
        begin
            ctrl_two_q <= `MCM_RST_CONV_CTRL_TWO;
            ctrl_three_q <= `MCM_RST_CONV_CTRL_THREE;
            mask_low_q <= `MCM_RST_IRQ_MASK_LOW;
            mask_high_q <= `MCM_RST_IRQ_MASK_HIGH;
        end
        else if (req_new && req_q.we)
        begin
            unique case (req_q.addr)
                `MCM_OFF_CONV_CTRL_TWO: ctrl_two_q <= {1'b0, req_q.wdata[6:0]};
                `MCM_OFF_CONV_CTRL_THREE: ctrl_three_q <= req_q.wdata;
                `MCM_OFF_IRQ_MASK_LOW: mask_low_q <= req_q.wdata;
                `MCM_OFF_IRQ_MASK_HIGH: mask_high_q <= req_q.wdata[4:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // interrupt gating
    // ------------------------------------------------------------------
    // registered so the pin never glitches while a mask is rewritten
    // masks gate levels, so unmasking a live source raises the pin next cycle
    // one cycle of latency is traded for a clean pin
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            irq_active_o <= 1'b0;
        else
            irq_active_o <= |(irq_src_i & ~{mask_high_q, mask_low_q});
    end

    // ------------------------------------------------------------------
    // serial clock timeout
    // ------------------------------------------------------------------
    logic scl_meta_q, scl_sync_q, scl_prev_q;
    logic [TMO_W-1:0] tmo_cnt_q;

    // the pin is asynchronous, so two flops come before any edge detection
    always_ff @(posedge clock_i)
    begin
        scl_meta_q <= scl_i;
        scl_sync_q <= scl_meta_q;
    end

    // a level that outlives the limit aborts once, then waits for an edge
    // holding the count at the limit keeps a stuck level from aborting twice
    // limitation: the limit is counted in core cycles and lags the pin
    // by the two synchroniser flops
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            scl_prev_q <= 1'b1;
            tmo_cnt_q <= '0;
            bus_abort_o <= 1'b0;
        end
        else
        begin
            scl_prev_q <= scl_sync_q;
            bus_abort_o <= 1'b0;
            if (!ctrl_two_q[`MCM_BIT_TMO_EN] || (scl_sync_q != scl_prev_q))
                tmo_cnt_q <= '0;
            else if (tmo_cnt_q == TMO_W'(TMO_CYCLES - 1))
            begin
                bus_abort_o <= 1'b1;
                tmo_cnt_q <= TMO_W'(TMO_CYCLES);
            end
            else if (tmo_cnt_q < TMO_W'(TMO_CYCLES))
                tmo_cnt_q <= tmo_cnt_q + TMO_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    mcm_seq_type seq_q;
    logic [3:0] rr_chan_q;
    logic [AVG_W-1:0] avg_cnt_q;
    logic [3:0] next_chan;
    logic last_sample;

    // reserved codes fall back to the supply channel
    // the host must avoid them; the fallback only keeps the adc on a real input
    function automatic logic [3:0] legal_chan(input logic [3:0] c);
        legal_chan = (c > `MCM_CHAN_LAST) ? `MCM_CHAN_SUPPLY : c;
    endfunction

    assign next_chan = ctrl_two_q[`MCM_BIT_SINGLE] ? legal_chan(ctrl_two_q[3:0])
                                                   : rr_chan_q;
    assign last_sample = conv_cfg_o.avg_off
                         || (avg_cnt_q == AVG_W'(`MCM_AVG_SAMPLES - 1));

    // settings are latched only at the first sample of a result
    // so all sixteen samples of an average share one setting
    // one result is one sample, or sixteen averaged samples
    // round robin steps through codes 0 to 9 and wraps to the supply
    // stopping mid-average drops the partial count; a restart begins afresh
    always_ff @(posedge clock_i)
    begin
        if (reset_i || soft_rst_q)
        begin
            seq_q <= MCM_SEQ_IDLE;
            conv_cfg_o <= '0;
            conv_req_o <= 1'b0;
            result_store_o <= 1'b0;
            avg_cnt_q <= '0;
            rr_chan_q <= `MCM_CHAN_SUPPLY;
        end
        else
        begin
            conv_req_o <= 1'b0;
            result_store_o <= 1'b0;
            unique case (seq_q)
                MCM_SEQ_IDLE:
                begin
                    if (!monitor_start_i)
                        avg_cnt_q <= '0;
                    else
                    begin
                        if (avg_cnt_q == '0)
                        begin
                            conv_cfg_o.chan <= next_chan;
                            conv_cfg_o.single <= ctrl_two_q[`MCM_BIT_SINGLE];
                            conv_cfg_o.avg_off <= ctrl_two_q[`MCM_BIT_AVG_OFF];
                            conv_cfg_o.fast <= ctrl_three_q[`MCM_BIT_FAST];
                            conv_cfg_o.ref_vdd <= ctrl_three_q[`MCM_BIT_REF_VDD];
                            conv_cfg_o.diode <= (next_chan == `MCM_CHAN_EXT_OR_ANALOG_INPUT_1)
                                && (pin_pair_sel_i == `MCM_PAIR_DIODE);
                        end
                        seq_q <= MCM_SEQ_REQ;
                    end
                end
                MCM_SEQ_REQ:
                begin
                    // one request pulse per sample
                    conv_req_o <= 1'b1;
                    seq_q <= MCM_SEQ_WAIT;
                end
                MCM_SEQ_WAIT:
                begin
                    if (conv_done_i)
                    begin
                        seq_q <= MCM_SEQ_IDLE;
                        if (last_sample)
                        begin
                            result_store_o <= 1'b1;
                            avg_cnt_q <= '0;
                            rr_chan_q <= (rr_chan_q == `MCM_CHAN_LAST) ? `MCM_CHAN_SUPPLY
                                         : rr_chan_q + 4'h1;
                        end
                        else
                            avg_cnt_q <= avg_cnt_q + AVG_W'(1);
                    end
                end
                default: seq_q <= MCM_SEQ_IDLE;
            endcase
        end
    end

endmodule // mcm_regs

`default_nettype wire

//--- include/mcm_map.svh
// register offsets, field positions, reset values and timing counts of the
// monitor configuration and mask bank; included by the package, whose macros the design uses.
`ifndef MCM_MAP_SVH
`define MCM_MAP_SVH

// ------------------------------------------------------------------
// offsets
// ------------------------------------------------------------------
`define MCM_OFF_CONV_CTRL_TWO 8'h19
`define MCM_OFF_CONV_CTRL_THREE 8'h1A
`define MCM_OFF_IRQ_MASK_LOW 8'h1D
`define MCM_OFF_IRQ_MASK_HIGH 8'h1E

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define MCM_BIT_SINGLE 4
`define MCM_BIT_AVG_OFF 5
`define MCM_BIT_TMO_EN 6
`define MCM_BIT_SOFT_RST 7
`define MCM_BIT_FAST 0
`define MCM_BIT_REF_VDD 4

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define MCM_RST_CONV_CTRL_TWO 8'h00
`define MCM_RST_CONV_CTRL_THREE 8'h08
`define MCM_RST_IRQ_MASK_LOW 8'h00
`define MCM_RST_IRQ_MASK_HIGH 5'h00

// ------------------------------------------------------------------
// channel codes, pin pair codes and counts
// ------------------------------------------------------------------
`define MCM_CHAN_SUPPLY 4'h0
`define MCM_CHAN_EXT_OR_ANALOG_INPUT_1 4'h2
`define MCM_CHAN_LAST 4'h9
`define MCM_PAIR_DIODE 2'h2
`define MCM_AVG_SAMPLES 16
`define MCM_CLK_HZ 25000000
`define MCM_TMO_MS 25
`define MCM_TMO_CYCLES ((`MCM_CLK_HZ / 1000) * `MCM_TMO_MS)

`endif

//--- include/mcm_pkg.sv
// types shared by the monitor configuration bank.
// assumes mcm_map.svh sits on the include path.
`include "mcm_map.svh"

package mcm_pkg;

    // settings that one conversion uses, latched at its start
    typedef struct packed {
        logic avg_off;
        logic fast;
        logic ref_vdd;
        logic diode;
        logic single;
        logic [3:0] chan;
    } mcm_cfg_type;

    // one serial register request held stable across the crossing
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcm_req_type;

    typedef enum logic [1:0] {
        MCM_SEQ_IDLE = 2'b00,
        MCM_SEQ_REQ = 2'b01,
        MCM_SEQ_WAIT = 2'b10
    } mcm_seq_type;

endpackage

//--- verif/mcm_adc_model.sv
// converter stand-in answering each sample request of the bank.
// assumes requests arrive as one-cycle pulses on clock_i.
`timescale 1ns/100ps
`default_nettype none
module mcm_adc_model
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic conv_req_i,
    input wire logic slow_i,
    output logic conv_done_o
);
    logic [3:0] cnt_q;
    // one done per request, after one or six cycles so both paces are seen
    always_ff @(posedge clock_i)
    begin
        conv_done_o <= 1'b0;
        if (reset_i)
            cnt_q <= 4'h0;
        else if (conv_req_i)
            cnt_q <= slow_i ? 4'h6 : 4'h1;
        else if (cnt_q != 4'h0)
        begin
            cnt_q <= cnt_q - 4'h1;
            conv_done_o <= (cnt_q == 4'h1);
        end
    end
endmodule // mcm_adc_model
`default_nettype wire

//--- verif/mcm_regs_properties.sv
// port checker of the monitor bank, bound into every mcm_regs.
// assumes reset_i also holds the link side in reset.
`timescale 1ns/100ps
`default_nettype none
module mcm_regs_properties
    import mcm_pkg::*;
#(
    parameter int TMO_CYCLES = 50
)
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic link_clk_i,
    input wire logic link_busy_o,
    input wire logic link_done_o,
    input wire logic scl_i,
    input wire logic bus_abort_o,
    input wire logic monitor_start_i,
    input wire logic conv_done_i,
    input wire logic conv_req_o,
    input wire mcm_cfg_type conv_cfg_o,
    input wire logic result_store_o,
    input wire logic [12:0] irq_src_i,
    input wire logic irq_active_o
);
    // ------------------------------------------------------------
    // core side
    // ------------------------------------------------------------
    chk_irq_quiet: assert property (@(posedge clock_i) disable iff (reset_i)
        irq_src_i == 13'h0000 |=> !irq_active_o) else $error("irq with no source");
    chk_start_gate: assert property (@(posedge clock_i) disable iff (reset_i)
        (!monitor_start_i)[*2] |=> !conv_req_o) else $error("sample while stopped");
    chk_store_cause: assert property (@(posedge clock_i) disable iff (reset_i)
        result_store_o |-> $past(conv_done_i)) else $error("store without done");
    chk_chan_legal: assert property (@(posedge clock_i) disable iff (reset_i)
        result_store_o |-> conv_cfg_o.chan <= 4'h9) else $error("reserved channel used");
    chk_diode_code: assert property (@(posedge clock_i) disable iff (reset_i)
        result_store_o && conv_cfg_o.diode |-> conv_cfg_o.chan == 4'h2) else $error("diode");
    chk_abort_still: assert property (@(posedge clock_i) disable iff (reset_i)
        bus_abort_o |-> $stable(scl_i) && $past(scl_i, 4) == scl_i) else $error("abort on edge");
    chk_abort_once: assert property (@(posedge clock_i) disable iff (reset_i)
        bus_abort_o |=> !bus_abort_o) else $error("abort too long");
    // ------------------------------------------------------------
    // link side, then covers on both clocks
    // ------------------------------------------------------------
    chk_done_pulse: assert property (@(posedge link_clk_i) disable iff (reset_i)
        link_done_o |=> !link_done_o) else $error("done too long");
    chk_busy_end: assert property (@(posedge link_clk_i) disable iff (reset_i)
        $fell(link_busy_o) |-> link_done_o) else $error("busy ended without done");
    cover property (@(posedge clock_i) result_store_o);
    cover property (@(posedge clock_i) bus_abort_o);
    cover property (@(posedge link_clk_i) link_done_o);
endmodule // mcm_regs_properties
bind mcm_regs mcm_regs_properties #(.TMO_CYCLES(TMO_CYCLES)) u_chk (.clock_i, .reset_i,
    .link_clk_i, .link_busy_o, .link_done_o, .scl_i, .bus_abort_o, .monitor_start_i,
    .conv_done_i, .conv_req_o, .conv_cfg_o, .result_store_o, .irq_src_i, .irq_active_o);
`default_nettype wire

//--- verif/mcm_regs_tb.sv
// self-checking bench of the monitor configuration and mask bank.
// assumes mcm_adc_model answers samples; timeout shortened to 50 cycles.
`timescale 1ns/100ps
`default_nettype none
module mcm_regs_tb
    import mcm_pkg::*;
;
    logic clock_i = 1'b0, reset_i = 1'b1, link_clk_i = 1'b0, link_req_i = 1'b0;
    logic link_we_i = 1'b0, scl_i = 1'b1, monitor_start_i = 1'b0, conv_done_i, slow_q = 1'b0;
    logic [7:0] link_addr_i = 8'h00, link_wdata_i = 8'h00, link_rdata_o;
    logic [1:0] pin_pair_sel_i = 2'h0;
    logic [12:0] irq_src_i = 13'h0000, msk = 13'h0000;
    logic link_busy_o, link_done_o, bus_abort_o, conv_req_o, result_store_o, irq_active_o;
    logic [31:0] rng = 32'h000000CC;
    mcm_cfg_type conv_cfg_o;
    int errors = 0, tests_run = 0, done_cnt = 0, req_cnt = 0, nreq = 0, aborts = 0;
    logic [7:0] lq[$];
    mcm_cfg_type cq[$];
    int nq[$];

    initial forever #20 clock_i = ~clock_i;
    // link clock offset so its edges never meet the core edges
    initial
    begin
        #7;
        forever #80 link_clk_i = ~link_clk_i;
    end

    mcm_regs #(.TMO_CYCLES(50)) u_dut (.clock_i, .reset_i, .link_clk_i, .link_req_i,
        .link_we_i, .link_addr_i, .link_wdata_i, .link_busy_o, .link_rdata_o, .link_done_o,
        .scl_i, .bus_abort_o, .monitor_start_i, .pin_pair_sel_i, .conv_done_i, .conv_req_o,
        .conv_cfg_o, .result_store_o, .irq_src_i, .irq_active_o);
    mcm_adc_model u_adc (.clock_i, .reset_i, .conv_req_i(conv_req_o), .slow_i(slow_q),
        .conv_done_o(conv_done_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp_byte(logic [7:0] g, logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %0t byte got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp_cfg(mcm_cfg_type g, int n, mcm_cfg_type e, int en);
        tests_run++;
        if (g !== e || n != en)
        begin
            errors++;
            $display("mismatch %0t result got %h/%0d exp %h/%0d", $time, g, n, e, en);
        end
    endtask

    task automatic tmo;
        errors++;
        $display("mismatch %0t wait ran out", $time);
        conclude();
    endtask

    // one register access; the expected read byte is queued first
    task automatic acc(logic we, logic [7:0] a, logic [7:0] d, logic [7:0] e);
        int c;
        c = done_cnt;
        lq.push_back(e);
        @(posedge link_clk_i);
        link_req_i <= 1'b1;
        link_we_i <= we;
        link_addr_i <= a;
        link_wdata_i <= d;
        @(posedge link_clk_i);
        link_req_i <= 1'b0;
        for (int i = 0; i < 40 && done_cnt == c; i++) @(posedge link_clk_i);
        if (done_cnt == c) tmo();
    endtask

    // monitors for n samples, then stops and lets the last result land
    task automatic run(int n);
        int t;
        t = req_cnt + n;
        @(posedge clock_i);
        monitor_start_i <= 1'b1;
        for (int i = 0; i < 2000 && req_cnt < t; i++) @(posedge clock_i);
        monitor_start_i <= 1'b0;
        if (req_cnt < t) tmo();
        repeat (40) @(posedge clock_i);
        cmp_byte(8'(cq.size()), 8'h00);
    endtask

    // ------------------------------------------------------------
    // result watchers
    // ------------------------------------------------------------
    always @(posedge link_clk_i)
    begin
        if (link_done_o === 1'b1)
        begin
            cmp_byte(link_rdata_o, lq.pop_front());
            done_cnt++;
        end
    end

    always @(posedge clock_i)
    begin
        if (conv_req_o === 1'b1)
        begin
            nreq++;
            req_cnt++;
        end
        if (bus_abort_o === 1'b1) aborts++;
        if (result_store_o === 1'b1)
        begin
            cmp_cfg(conv_cfg_o, nreq, cq.pop_front(), nq.pop_front());
            nreq = 0;
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (8) @(posedge link_clk_i);
        acc(0, 8'h19, 8'h00, 8'h00);
        acc(0, 8'h1A, 8'h00, 8'h08);
        acc(0, 8'h1D, 8'h00, 8'h00);
        acc(0, 8'h1E, 8'h00, 8'h00);
        acc(0, 8'h1F, 8'h00, 8'h00);
        rng = xs(rng);
        acc(1, 8'h1D, rng[7:0], 8'h00);
        acc(0, 8'h1D, 8'h00, rng[7:0]);
        acc(1, 8'h1E, {3'h0, rng[12:8]}, 8'h00);
        acc(0, 8'h1E, 8'h00, {3'h0, rng[12:8]});
        $display("end of register defaults");
        // each source alone, first with only its own mask bit set, then all others set
        for (int i = 0; i < 26; i++)
        begin
            msk = (i < 13) ? 13'h0001 << (i % 13) : ~(13'h0001 << (i % 13));
            acc(1, 8'h1D, msk[7:0], 8'h00);
            acc(1, 8'h1E, {3'h0, msk[12:8]}, 8'h00);
            @(posedge clock_i);
            irq_src_i <= 13'h0001 << (i % 13);
            repeat (3) @(posedge clock_i);
            cmp_byte({7'h00, irq_active_o}, 8'(i >= 13));
        end
        irq_src_i <= 13'h0000;
        $display("end of interrupt masks");
        for (int c = 0; c < 10; c++)
        begin
            rng = xs(rng);
            slow_q <= rng[0];
            acc(1, 8'h19, {4'h3, c[3:0]}, 8'h00);
            acc(1, 8'h1A, {3'h0, rng[2], 3'h4, rng[3]}, 8'h00);
            cq.push_back({1'b1, rng[3], rng[2], c == 2 && rng[1], 1'b1, c[3:0]});
            nq.push_back(1);
            @(posedge clock_i);
            pin_pair_sel_i <= {rng[1], 1'b0};
            run(1);
        end
        $display("end of single channel");
        acc(1, 8'h1D, 8'hAA, 8'h00);
        acc(1, 8'h19, 8'h80, 8'h00);
        acc(0, 8'h1D, 8'h00, 8'h00);
        acc(0, 8'h19, 8'h00, 8'h00);
        acc(0, 8'h1A, 8'h00, 8'h08);
        $display("end of software reset");
        acc(1, 8'h19, 8'h20, 8'h00);
        for (int k = 0; k < 12; k++) cq.push_back({5'h10, 4'(k % 10)});
        for (int k = 0; k < 12; k++) nq.push_back(1);
        @(posedge clock_i);
        pin_pair_sel_i <= 2'h0;
        run(12);
        acc(1, 8'h19, 8'h15, 8'h00);
        cq.push_back({5'h01, 4'h5});
        nq.push_back(16);
        run(16);
        $display("end of sequencing");
        repeat (100) @(posedge clock_i);
        cmp_byte(8'(aborts), 8'h00);
        acc(1, 8'h19, 8'h40, 8'h00);
        for (int i = 0; i < 20; i++)
        begin
            repeat (10) @(posedge clock_i);
            scl_i <= ~scl_i;
        end
        cmp_byte(8'(aborts), 8'h00);
        repeat (100) @(posedge clock_i);
        cmp_byte(8'(aborts), 8'h01);
        $display("end of clock timeout");
        conclude();
    end
endmodule // mcm_regs_tb
`default_nettype wire
